// >>> core/spc_pkg.sv
package spc_pkg;

    // Serial frame geometry.
    localparam int unsigned ADDR_W      = 15;
    localparam int unsigned INSTR_W     = 16;
    localparam int unsigned BYTE_W      = 8;
    localparam logic [3:0]  INSTR_LAST  = 4'hf;
    localparam logic [3:0]  BYTE_LAST   = 4'h7;
    localparam int unsigned RW_POS      = 15;

    // Register offsets.
    localparam logic [ADDR_W-1:0] REG_PRIMARY   = 15'h0000;
    localparam logic [ADDR_W-1:0] REG_SECONDARY = 15'h0001;
    localparam logic [ADDR_W-1:0] ADDR_STEP     = 15'h0001;

    // Primary register field positions.
    localparam int unsigned PRI_SOFT_RESET = 0;
    localparam int unsigned PRI_BIT_ORDER  = 1;
    localparam int unsigned PRI_ADDR_DIR   = 2;
    localparam int unsigned PRI_FOUR_WIRE  = 3;
    localparam int unsigned PRI_LOW_W      = 4;

    // Secondary register field positions.
    localparam int unsigned SEC_RESERVED_0 = 0;
    localparam int unsigned SEC_RESET_A    = 1;
    localparam int unsigned SEC_RESET_B    = 2;
    localparam int unsigned SEC_HOLD       = 6;
    localparam int unsigned SEC_SINGLE     = 7;

    // Reset values and writable masks.
    localparam logic [3:0]  PRI_RESET     = 4'h0;
    localparam logic [7:0]  SEC_RESET     = 8'h00;
    localparam logic [7:0]  SEC_WR_MASK   = 8'hfe;
    localparam logic [7:0]  READ_UNMAPPED = 8'h00;

    // Soft reset pulse length.
    localparam int unsigned CLK_PERIOD_NS  = 5;
    localparam int unsigned PULSE_TIME_NS  = 20;
    localparam int unsigned PULSE_CYCLES   = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PULSE_W        = 4;
    localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_W'(PULSE_CYCLES);
    localparam logic [PULSE_W-1:0] PULSE_ONE  = 4'h1;
    localparam logic [PULSE_W-1:0] PULSE_ZERO = 4'h0;

    // Soft reset line indices.
    localparam int unsigned LINE_MAIN = 0;
    localparam int unsigned LINE_A    = 1;
    localparam int unsigned LINE_B    = 2;
    localparam int unsigned LINES     = 3;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic sdio_in;
    } spc_pins_in_t;

    typedef struct packed {
        logic sdio_out;
        logic sdio_oe;
        logic sdo_out;
        logic sdo_oe;
    } spc_pins_out_t;

    typedef struct packed {
        logic soft_reset_main;
        logic soft_reset_line_a;
        logic soft_reset_line_b;
    } spc_resets_t;

    typedef struct packed {
        logic four_wire_select;
        logic bit_order_select;
        logic address_direction;
        logic single_transfer_select;
        logic select_line_hold;
    } spc_cfg_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_INSTR = 4'b0010,
        ST_DATA  = 4'b0100,
        ST_DONE  = 4'b1000
    } spc_state_t;

endpackage

// >>> core/spc_serial_port.sv
`timescale 1ns/100ps
module spc_serial_port
    import spc_pkg::*;
(
    input  wire logic               clk,      // System clock, 200 MHz.
    input  wire logic               srst,     // Synchronous reset, active high.
    input  wire spc_pkg::spc_pins_in_t  pins_in,  // Chip select, serial clock, data in.
    output spc_pkg::spc_pins_out_t      pins_out, // Data out pins and their enables.
    output spc_pkg::spc_resets_t        resets,   // Soft reset pulses to the device.
    output spc_pkg::spc_cfg_t           cfg       // Live configuration bits.
);
    import spc_pkg::*;

    // Input synchronisers; the first stage feeds only the second.
    spc_pins_in_t sync1;
    spc_pins_in_t sync2;
    logic         sclk_d;

    always_ff @(posedge clk) begin
        if (srst) begin
            sync1  <= '{cs_n: 1'b1, sclk: 1'b0, sdio_in: 1'b0};
            sync2  <= '{cs_n: 1'b1, sclk: 1'b0, sdio_in: 1'b0};
            sclk_d <= 1'b0;
        end else begin
            sync1  <= pins_in;
            sync2  <= sync1;
            sclk_d <= sync2.sclk;
        end
    end

    // Serial clock edges are found in the cycle the second synchroniser stage changes, against its delayed copy.
    // That costs about three system cycles, well inside either half of the link period.
    logic sclk_rise;
    logic sclk_fall;
    logic data_bit;
    logic cs_active;

    assign sclk_rise = sync2.sclk & ~sclk_d;
    assign sclk_fall = ~sync2.sclk & sclk_d;
    assign data_bit  = sync2.sdio_in;
    assign cs_active = ~sync2.cs_n;

    // Register storage.
    // Only the four writable bits of the primary register are stored.
    logic [PRI_LOW_W-1:0] pri;
    logic [7:0]           sec;
    logic [PULSE_W-1:0]   pulse_cnt [LINES];
    logic [LINES-1:0]     pulse;

    // Read data for one address; unmapped addresses return a fixed value.
    // The primary upper nibble is built from the lower bits in reverse order.
    function automatic logic [7:0] read_byte(input logic [ADDR_W-1:0] a,
                                             input logic [PRI_LOW_W-1:0] p,
                                             input logic [7:0] s);
        logic [7:0] r;
        r = READ_UNMAPPED;
        if (a == REG_PRIMARY) begin
            r = {p[PRI_SOFT_RESET],
                 p[PRI_BIT_ORDER],
                 p[PRI_ADDR_DIR],
                 p[PRI_FOUR_WIRE],
                 p};
        end else if (a == REG_SECONDARY) begin
            r = s & SEC_WR_MASK;
        end
        return r;
    endfunction

    // Transaction state.
    spc_state_t          state;
    spc_state_t          next_state;
    logic [3:0]          cnt;
    logic [3:0]          next_cnt;
    logic [INSTR_W-1:0]  instr_sr;
    logic [INSTR_W-1:0]  next_instr_sr;
    logic [ADDR_W-1:0]   addr;
    logic [ADDR_W-1:0]   next_addr;
    logic                is_read;
    logic                next_is_read;
    logic [7:0]          in_sr;
    logic [7:0]          next_in_sr;
    logic [7:0]          out_sr;
    logic [7:0]          next_out_sr;
    logic                dout;
    logic                next_dout;
    logic                drive;
    logic                next_drive;
    spc_cfg_t            act;
    spc_cfg_t            next_act;
    logic                wr_en;
    logic [ADDR_W-1:0]   wr_addr;
    logic [7:0]          wr_data;

    // Frame machine: chip select low opens an instruction, then data bytes follow.
    // The configuration is copied into act when a frame opens, so a write lands on the next frame.
    always_comb begin
        logic [INSTR_W-1:0] word;
        logic [7:0]         byte_in;
        logic [ADDR_W-1:0]  stepped;
        word          = '0;
        byte_in       = '0;
        stepped       = '0;
        next_state    = state;
        next_cnt      = cnt;
        next_instr_sr = instr_sr;
        next_addr     = addr;
        next_is_read  = is_read;
        next_in_sr    = in_sr;
        next_out_sr   = out_sr;
        next_dout     = dout;
        next_drive    = drive;
        next_act      = act;
        wr_en         = 1'b0;
        wr_addr       = addr;
        wr_data       = '0;
        if (!cs_active) begin
            // A partial byte at the end of a frame is dropped and the data line released.
            next_state = ST_IDLE;
            next_drive = 1'b0;
            next_cnt   = '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    // Latch the configuration for the whole frame.
                    next_act   = cfg;
                    next_state = ST_INSTR;
                    next_cnt   = '0;
                end
                ST_INSTR: begin
                    if (sclk_rise) begin
                        word = act.bit_order_select ? {data_bit, instr_sr[INSTR_W-1:1]}
                                                    : {instr_sr[INSTR_W-2:0], data_bit};
                        next_instr_sr = word;
                        next_cnt      = cnt + 4'h1;
                        // The sixteenth bit completes the instruction; the first read byte is fetched at once.
                        if (cnt == INSTR_LAST) begin
                            next_is_read = word[RW_POS];
                            next_addr    = word[ADDR_W-1:0];
                            next_out_sr  = read_byte(word[ADDR_W-1:0], pri, sec);
                            next_state   = ST_DATA;
                            next_cnt     = '0;
                        end
                    end
                end
                ST_DATA: begin
                    if (sclk_rise) begin
                        byte_in = act.bit_order_select ? {data_bit, in_sr[7:1]}
                                                       : {in_sr[6:0], data_bit};
                        next_in_sr = byte_in;
                        next_cnt   = cnt + 4'h1;
                        if (cnt == BYTE_LAST) begin
                            next_cnt = '0;
                            wr_en    = ~is_read;
                            wr_data  = byte_in;
                            stepped  = act.address_direction ? addr + ADDR_STEP : addr - ADDR_STEP;
                            next_addr   = stepped;
                            next_out_sr = read_byte(stepped, pri, sec);
                            if (act.single_transfer_select) begin
                                next_state = ST_DONE;
                            end
                        end
                    end else if (sclk_fall && is_read) begin
                        // Data moves on the falling edge so it is settled when the host samples.
                        next_dout  = act.bit_order_select ? out_sr[0] : out_sr[7];
                        next_out_sr = act.bit_order_select ? {1'b0, out_sr[7:1]} : {out_sr[6:0], 1'b0};
                        next_drive = 1'b1;
                    end
                end
                // Single-transfer mode: later bytes of the frame are neither written nor driven.
                ST_DONE: begin
                    if (sclk_fall) begin
                        next_drive = 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state    <= ST_IDLE;
            cnt      <= '0;
            instr_sr <= '0;
            addr     <= '0;
            is_read  <= 1'b0;
            in_sr    <= '0;
            out_sr   <= '0;
            dout     <= 1'b0;
            drive    <= 1'b0;
            act      <= '0;
        end else begin
            state    <= next_state;
            cnt      <= next_cnt;
            instr_sr <= next_instr_sr;
            addr     <= next_addr;
            is_read  <= next_is_read;
            in_sr    <= next_in_sr;
            out_sr   <= next_out_sr;
            dout     <= next_dout;
            drive    <= next_drive;
            act      <= next_act;
        end
    end

    // Register group; a host write in the same cycle as a self-clear wins.
    // Write data arrives from the frame machine in the same cycle the eighth rising edge is detected.
    // Each soft reset line has a down counter and stays high while it is non-zero.
    // The main line clears both registers as its pulse ends, which drops its own request bit.
    logic [PRI_LOW_W-1:0] next_pri;
    logic [7:0]           next_sec;
    logic [PULSE_W-1:0]   next_pulse_cnt [LINES];
    logic [LINES-1:0]     next_pulse;
    logic [LINES-1:0]     start;

    always_comb begin
        next_pri = pri;
        next_sec = sec;
        start    = '0;
        for (int i = 0; i < LINES; i++) begin
            next_pulse_cnt[i] = pulse_cnt[i];
            if (pulse_cnt[i] != PULSE_ZERO) begin
                next_pulse_cnt[i] = pulse_cnt[i] - PULSE_ONE;
            end
        end
        if (pulse_cnt[LINE_MAIN] == PULSE_ONE) begin
            next_pri = PRI_RESET;
            next_sec = SEC_RESET;
        end
        if (pulse_cnt[LINE_A] == PULSE_ONE) begin
            next_sec[SEC_RESET_A] = 1'b0;
        end
        if (pulse_cnt[LINE_B] == PULSE_ONE) begin
            next_sec[SEC_RESET_B] = 1'b0;
        end
        if (wr_en && wr_addr == REG_PRIMARY) begin
            next_pri = wr_data[PRI_LOW_W-1:0];
            start[LINE_MAIN] = wr_data[PRI_SOFT_RESET];
        end
        if (wr_en && wr_addr == REG_SECONDARY) begin
            next_sec = wr_data & SEC_WR_MASK;
            start[LINE_A] = wr_data[SEC_RESET_A];
            start[LINE_B] = wr_data[SEC_RESET_B];
        end
        for (int i = 0; i < LINES; i++) begin
            if (start[i]) begin
                next_pulse_cnt[i] = PULSE_LOAD;
            end
            next_pulse[i] = (next_pulse_cnt[i] != PULSE_ZERO);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pri   <= PRI_RESET;
            sec   <= SEC_RESET;
            pulse <= '0;
            for (int i = 0; i < LINES; i++) begin
                pulse_cnt[i] <= PULSE_ZERO;
            end
        end else begin
            pri   <= next_pri;
            sec   <= next_sec;
            pulse <= next_pulse;
            for (int i = 0; i < LINES; i++) begin
                pulse_cnt[i] <= next_pulse_cnt[i];
            end
        end
    end

    // Soft reset pulses come from flops, so they carry no glitches.
    assign resets.soft_reset_main   = pulse[LINE_MAIN];
    assign resets.soft_reset_line_a = pulse[LINE_A];
    assign resets.soft_reset_line_b = pulse[LINE_B];

    // Live configuration levels, straight from the register flops.
    assign cfg.four_wire_select       = pri[PRI_FOUR_WIRE];
    assign cfg.bit_order_select       = pri[PRI_BIT_ORDER];
    assign cfg.address_direction      = pri[PRI_ADDR_DIR];
    assign cfg.single_transfer_select = sec[SEC_SINGLE];
    assign cfg.select_line_hold       = sec[SEC_HOLD];

    // Read data leaves on sdo in four-wire mode, otherwise on the shared sdio line.
    assign pins_out.sdo_out  = dout;
    assign pins_out.sdo_oe   = drive & act.four_wire_select;
    assign pins_out.sdio_out = dout;
    assign pins_out.sdio_oe  = drive & ~act.four_wire_select;

endmodule

// >>> test/spc_asserts.sv
`timescale 1ns/100ps
module spc_asserts
    import spc_pkg::*;
(
    input wire logic                   clk,      // System clock.
    input wire logic                   srst,     // Synchronous reset.
    input wire spc_pkg::spc_pins_in_t  pins_in,  // Pins from the host.
    input wire spc_pkg::spc_pins_out_t pins_out, // Pins to the host.
    input wire spc_pkg::spc_resets_t   resets,   // Soft reset pulses.
    input wire spc_pkg::spc_cfg_t      cfg       // Live configuration.
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_four(x);
        x[*4] ##1 !x;
    endsequence
    property p_main;
        $rose(resets.soft_reset_main) |-> s_four(resets.soft_reset_main);
    endproperty
    a_main: assert property (p_main) else $error("main pulse length");
    property p_line_a;
        $rose(resets.soft_reset_line_a) |-> s_four(resets.soft_reset_line_a);
    endproperty
    a_line_a: assert property (p_line_a) else $error("line a pulse length");
    property p_line_b;
        $rose(resets.soft_reset_line_b) |-> s_four(resets.soft_reset_line_b);
    endproperty
    a_line_b: assert property (p_line_b) else $error("line b pulse length");
    property p_main_clear;
        $fell(resets.soft_reset_main) |-> ##[0:1] (cfg == '0);
    endproperty
    a_main_clear: assert property (p_main_clear) else $error("config kept");
    property p_sdo_mode;
        pins_out.sdo_oe |-> cfg.four_wire_select && !pins_out.sdio_oe;
    endproperty
    a_sdo_mode: assert property (p_sdo_mode) else $error("sdo in 3-wire");
    property p_sdio_mode;
        pins_out.sdio_oe |-> !cfg.four_wire_select;
    endproperty
    a_sdio_mode: assert property (p_sdio_mode) else $error("sdio in 4-wire");
    property p_idle;
        pins_in.cs_n[*4] |-> !pins_out.sdio_oe && !pins_out.sdo_oe;
    endproperty
    a_idle: assert property (p_idle) else $error("drive while idle");
    property p_stand;
        pins_in.sclk[*5] |-> $stable(pins_out.sdio_out) && pins_out.sdo_out == pins_out.sdio_out;
    endproperty
    a_stand: assert property (p_stand) else $error("data moved");
    property p_cfg_frame;
        $changed(cfg) |-> !pins_in.cs_n;
    endproperty
    a_cfg_frame: assert property (p_cfg_frame) else $error("config outside frame");
endmodule
bind spc_serial_port spc_asserts u_spc_asserts (.clk(clk), .srst(srst), .pins_in(pins_in),
    .pins_out(pins_out), .resets(resets), .cfg(cfg));

// >>> test/spc_host.sv
`timescale 1ns/100ps
module spc_host (
    input  wire logic clk,         // System clock.
    input  wire logic sdio_line,   // Resolved sdio wire.
    input  wire logic sdo_line,    // Resolved sdo wire.
    output logic      cs_n = 1'b1, // Chip select, active low.
    output logic      sclk = 1'b0, // Serial clock, idle low.
    output logic      mosi = 1'b0  // Host data to sdio.
);
    task automatic half(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Link period is 25 clk cycles: 12 low, 13 high.
    task automatic bits(input logic [15:0] v, input int n, input logic [1:0] md, output logic [15:0] r);
        r = '0;
        for (int i = 0; i < n; i++) begin
            mosi <= md[0] ? v[i] : v[n-1-i];
            half(12);
            sclk <= 1'b1;
            half(1);
            r[md[0] ? i : n-1-i] = md[1] ? sdo_line : sdio_line;
            half(12);
            sclk <= 1'b0;
        end
    endtask
    task automatic frame(input logic [15:0] ins, input logic [15:0] wd, input int nb, input logic [1:0] md,
                         output logic [15:0] rd);
        logic [15:0] r;
        rd = '0;
        cs_n <= 1'b0;
        half(13);
        bits(ins, 16, md, r);
        for (int b = 0; b < nb; b++) begin
            bits({8'h00, wd[8*b +: 8]}, 8, md, r);
            rd[8*b +: 8] = r[7:0];
        end
        half(13);
        cs_n <= 1'b1;
        half(25);
    endtask
endmodule

// >>> test/tb.sv
`timescale 1ns/100ps
module tb;
    import spc_pkg::*;
    logic          clk      = 1'b0;
    logic          srst     = 1'b1;
    logic          tog      = 1'b0;
    logic          cs_n;
    logic          sclk;
    logic          mosi;
    logic          sdio_line;
    logic          sdo_line;
    logic [15:0]   rd;
    int            n_fail   = 0;
    int            compares = 0;
    spc_pins_in_t  pins_in;
    spc_pins_out_t pins_out;
    spc_resets_t   resets;
    spc_cfg_t      cfg;
    always #2.5 clk = ~clk;
    // A released sdo wire toggles so a missing drive cannot match.
    always @(posedge clk) tog <= ~tog;
    assign sdio_line = pins_out.sdio_oe ? pins_out.sdio_out : mosi;
    assign sdo_line  = pins_out.sdo_oe ? pins_out.sdo_out : tog;
    assign pins_in   = '{cs_n: cs_n, sclk: sclk, sdio_in: sdio_line};
    spc_serial_port u_spc_serial_port (.clk(clk), .srst(srst), .pins_in(pins_in), .pins_out(pins_out),
                                       .resets(resets), .cfg(cfg));
    spc_host u_spc_host (.clk(clk), .sdio_line(sdio_line), .sdo_line(sdo_line), .cs_n(cs_n),
                         .sclk(sclk), .mosi(mosi));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [14:0] a, input logic [15:0] d, input int nb, input logic [1:0] md);
        u_spc_host.frame({1'b0, a}, d, nb, md, rd);
    endtask
    task automatic rdc(input logic [14:0] a, input int nb, input logic [1:0] md, input logic [15:0] exp);
        u_spc_host.frame({1'b1, a}, 16'h0000, nb, md, rd);
        chk(rd, exp);
    endtask
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        finish_test();
    end
    // Mode argument is {four_wire, lsb_first}; upper nibble is the lower nibble reversed.
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        rdc(REG_PRIMARY, 1, 2'b00, 16'h0000);
        rdc(REG_SECONDARY, 1, 2'b00, 16'h0000);
        wr(15'h0005, 16'h00ff, 1, 2'b00);
        rdc(15'h0005, 1, 2'b00, 16'h0000);
        wr(REG_SECONDARY, 16'h0079, 1, 2'b00);
        rdc(REG_SECONDARY, 1, 2'b00, 16'h0078);
        chk({15'h0000, cfg.select_line_hold}, 16'h0001);
        wr(REG_SECONDARY, 16'h0006, 1, 2'b00);
        rdc(REG_SECONDARY, 1, 2'b00, 16'h0000);
        wr(REG_PRIMARY, 16'h00fc, 1, 2'b00);
        chk({15'h0000, cfg.four_wire_select}, 16'h0001);
        wr(REG_PRIMARY, 16'h780c, 2, 2'b10);
        rdc(REG_PRIMARY, 2, 2'b10, 16'h783c);
        wr(REG_PRIMARY, 16'h0008, 1, 2'b10);
        rdc(REG_SECONDARY, 2, 2'b10, 16'h1878);
        wr(REG_PRIMARY, 16'h0002, 1, 2'b10);
        rdc(REG_PRIMARY, 1, 2'b01, 16'h0042);
        wr(REG_SECONDARY, 16'h0080, 1, 2'b01);
        wr(REG_SECONDARY, 16'h0c80, 2, 2'b01);
        rdc(REG_PRIMARY, 1, 2'b01, 16'h0042);
        rdc(REG_SECONDARY, 1, 2'b01, 16'h0080);
        wr(REG_PRIMARY, 16'h0001, 1, 2'b01);
        rdc(REG_PRIMARY, 1, 2'b00, 16'h0000);
        rdc(REG_SECONDARY, 1, 2'b00, 16'h0000);
        wr(REG_SECONDARY, 16'h0038, 1, 2'b00);
        srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        rdc(REG_SECONDARY, 1, 2'b00, 16'h0000);
        finish_test();
    end
endmodule
